// *** src/alsc_top.sv ***
// Control logic of the ambient light sensor with its Avalon-MM register slave
//
// The placing of the registers and register access over Avalon-MM were decided locally.

// How it works
// (R01) Up to 16-bit conversion, 105 ms; lower res or fast osc shortens it.
// (R02) Auto mode runs one conversion then powers the converter down.
// (R03) Software power-down is entered and left only by a control write.
// (R04) Brownout flag is set at power-up until the host clears it.
// (R05) Interrupt flag and pin stay asserted until the host clears the flag.
// (R06) Conversions keep running while an interrupt is outstanding.
// (R07) Open-drain interrupt pin is pulled low while the flag is set.
// (R08) Lux range setting scales counts per lux of the result.
// (R09) Interrupt rises on a threshold crossing repeated per persistence.
// (R10) Host reaches all registers over the bus; control acts at completion.
module alsc_top #(
  parameter int CONV_CYC = alsc_pkg::CONV_CYC
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic comp_i,
  output logic int_o,
  output logic int_oe_o,
  output logic irq_o,
  output logic powered_o
);

  localparam int TICK_RAW = CONV_CYC / alsc_pkg::ADC_STEPS;
  localparam int TICK_CYC =
    (TICK_RAW < alsc_pkg::TICK_MIN) ? alsc_pkg::TICK_MIN : TICK_RAW;

  ////////////////////////////////////////////////////////////////////////////
  // Functions
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      m[8*i +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  function automatic logic [15:0] lux_scale(input logic [15:0] raw,
                                            input logic [1:0] rng);
    // Each range step gives a quarter of the counts per lux
    return raw >> {rng, 1'b0};
  endfunction

  function automatic logic [4:0] persist_need(input logic [1:0] p);
    logic [4:0] n;
    n = alsc_pkg::PERSIST_N3;
    case (p)
      2'b00: n = alsc_pkg::PERSIST_N0;
      2'b01: n = alsc_pkg::PERSIST_N1;
      2'b10: n = alsc_pkg::PERSIST_N2;
      default: n = alsc_pkg::PERSIST_N3;
    endcase
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic req;
  logic wr_go;
  logic [31:0] wmask;
  logic [31:0] wdata_m;
  logic [31:0] rd_mux;
  alsc_pkg::alsc_ctrl_s ctrl_ff;
  alsc_pkg::alsc_ctrl_s nxt_ctrl;
  logic ctrl_wr;
  logic flags_wr;
  logic [15:0] thr_lo_ff;
  logic [15:0] thr_hi_ff;
  logic [15:0] data_ff;
  logic brownout_ff;
  logic int_flag_ff;
  logic [alsc_pkg::IRQ_W-1:0] irq_stat_ff;
  logic [alsc_pkg::IRQ_W-1:0] irq_en_ff;
  logic [alsc_pkg::IRQ_W-1:0] irq_clr;
  logic [alsc_pkg::IRQ_W-1:0] irq_set;
  logic irq_ff;
  logic int_oe_ff;
  logic comp_meta_ff;
  logic comp_sync_ff;
  alsc_pkg::alsc_state_e state_ff;
  alsc_pkg::alsc_state_e nxt_state;
  logic start_ff;
  logic nxt_start;
  logic abort_ff;
  logic nxt_abort;
  alsc_pkg::alsc_conv_s conv;
  logic [15:0] scaled;
  logic outside;
  logic [4:0] pcnt_ff;
  logic [4:0] pcnt_inc;
  logic thr_evt;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait state, answer in the cycle after the request
  assign req = (avs_read_i || avs_write_i) && wait_ff;
  assign wr_go = avs_write_i && !wait_ff;
  assign wmask = be_mask(avs_byteenable_i);
  assign wdata_m = avs_writedata_i & wmask;
  // Control writes take effect at the completing edge only (R10)
  assign ctrl_wr = wr_go && (avs_address_i == alsc_pkg::OFS_CTRL); // R10
  assign flags_wr = wr_go && (avs_address_i == alsc_pkg::OFS_FLAGS);
  assign irq_clr = (wr_go && (avs_address_i == alsc_pkg::OFS_IRQ_CLR)) ?
                   wdata_m[alsc_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= !req;
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    case (avs_address_i)
      alsc_pkg::OFS_CTRL: rd_mux[alsc_pkg::CTRL_W-1:0] = ctrl_ff;
      alsc_pkg::OFS_FLAGS: begin
        rd_mux[alsc_pkg::FLG_BROWNOUT] = brownout_ff;
        rd_mux[alsc_pkg::FLG_INT] = int_flag_ff;
        rd_mux[alsc_pkg::FLG_BUSY] = conv.busy;
      end
      alsc_pkg::OFS_DATA: rd_mux[15:0] = data_ff;
      alsc_pkg::OFS_THR_LO: rd_mux[15:0] = thr_lo_ff;
      alsc_pkg::OFS_THR_HI: rd_mux[15:0] = thr_hi_ff;
      alsc_pkg::OFS_IRQ_STAT: rd_mux[alsc_pkg::IRQ_W-1:0] = irq_stat_ff;
      alsc_pkg::OFS_IRQ_EN: rd_mux[alsc_pkg::IRQ_W-1:0] = irq_en_ff;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_ff <= 32'h00000000;
    end else if (req && avs_read_i) begin
      rdata_ff <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read/write settings
  assign nxt_ctrl = (ctrl_ff & ~wmask[alsc_pkg::CTRL_W-1:0]) |
                    wdata_m[alsc_pkg::CTRL_W-1:0];

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_ff <= alsc_pkg::CTRL_RST;
      thr_lo_ff <= alsc_pkg::THR_LO_RST;
      thr_hi_ff <= alsc_pkg::THR_HI_RST;
      irq_en_ff <= alsc_pkg::IRQ_EN_RST;
    end else if (wr_go) begin
      case (avs_address_i)
        alsc_pkg::OFS_CTRL: ctrl_ff <= nxt_ctrl;
        alsc_pkg::OFS_THR_LO:
          thr_lo_ff <= (thr_lo_ff & ~wmask[15:0]) | wdata_m[15:0];
        alsc_pkg::OFS_THR_HI:
          thr_hi_ff <= (thr_hi_ff & ~wmask[15:0]) | wdata_m[15:0];
        alsc_pkg::OFS_IRQ_EN:
          irq_en_ff <= wdata_m[alsc_pkg::IRQ_W-1:0] |
                       (irq_en_ff & ~wmask[alsc_pkg::IRQ_W-1:0]);
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparator bit from the analog modulator is asynchronous
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      comp_meta_ff <= 1'b0;
      comp_sync_ff <= 1'b0;
    end else begin
      comp_meta_ff <= comp_i;
      comp_sync_ff <= comp_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurement sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_start = 1'b0;
    nxt_abort = 1'b0;
    if (ctrl_wr) begin
      // Every control write restarts or stops the converter (R03)
      case (nxt_ctrl.mode)
        alsc_pkg::MODE_CONT, alsc_pkg::MODE_AUTO: begin
          nxt_state = alsc_pkg::ST_CONV;
          nxt_start = 1'b1;
        end
        default: begin
          nxt_state = alsc_pkg::ST_OFF; // R03
          nxt_abort = 1'b1;
        end
      endcase
    end else if (conv.done) begin
      case (state_ff)
        alsc_pkg::ST_CONV: begin
          if (ctrl_ff.mode == alsc_pkg::MODE_CONT) begin
            // Interrupt state is not consulted here (R06)
            nxt_start = 1'b1; // R06
          end else begin
            nxt_state = alsc_pkg::ST_OFF; // R02
          end
        end
        default: nxt_state = alsc_pkg::ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= alsc_pkg::ST_OFF;
      start_ff <= 1'b0;
      abort_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      start_ff <= nxt_start;
      abort_ff <= nxt_abort;
    end
  end

  alsc_conv #(
    .TICK_CYC(TICK_CYC)
  ) u_conv (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .start_i(start_ff),
    .abort_i(abort_ff),
    .res_i(ctrl_ff.res),
    .osc_fast_i(ctrl_ff.osc_fast),
    .comp_i(comp_sync_ff),
    .conv_o(conv)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Result and threshold window with persistence
  assign scaled = lux_scale(conv.raw, ctrl_ff.range); // R08
  assign outside = (scaled < thr_lo_ff) || (scaled > thr_hi_ff); // R09
  assign pcnt_inc = pcnt_ff + 5'h01;
  assign thr_evt = conv.done && outside &&
                   (pcnt_inc >= persist_need(ctrl_ff.persist)); // R09

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_ff <= alsc_pkg::DATA_RST;
      pcnt_ff <= 5'h00;
    end else if (conv.done) begin
      data_ff <= scaled; // R08
      // A result back inside the window restarts the run count
      if (!outside || thr_evt) begin
        pcnt_ff <= 5'h00; // R09
      end else begin
        pcnt_ff <= pcnt_inc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host-cleared flags; a set in the clearing cycle wins
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      brownout_ff <= 1'b1; // R04
    end else if (flags_wr && wdata_m[alsc_pkg::FLG_BROWNOUT]) begin
      brownout_ff <= 1'b0; // R04
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_flag_ff <= 1'b0;
    end else if (thr_evt) begin
      int_flag_ff <= 1'b1; // R05
    end else if (flags_wr && wdata_m[alsc_pkg::FLG_INT]) begin
      int_flag_ff <= 1'b0; // R05
    end
  end

  assign irq_set[alsc_pkg::IRQ_DONE] = conv.done;
  assign irq_set[alsc_pkg::IRQ_THR] = thr_evt;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_ff <= 1'b0;
      int_oe_ff <= 1'b0;
    end else begin
      irq_ff <= |(irq_stat_ff & irq_en_ff);
      // Pin follows the flag, so it cannot drop while the flag stands
      int_oe_ff <= int_flag_ff; // R05 R07
    end
  end

  // Open-drain: only ever drives low
  assign int_o = 1'b0; // R07
  assign int_oe_o = int_oe_ff;
  assign irq_o = irq_ff;
  assign avs_readdata_o = rdata_ff;
  assign avs_waitrequest_o = wait_ff;
  assign powered_o = conv.busy;

endmodule

// *** common/alsc_pkg.sv ***
// Shared constants, register map and carrier types of the light sensor control
package alsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int CONV_TIME_MS = 105;
  localparam int CONV_CYC = CONV_TIME_MS * 1000 * CLK_MHZ;
  localparam int ADC_BITS = 16;
  localparam int ADC_STEPS = 65536;
  localparam int TICK_MIN = 1;
  localparam int DIV_W = 24;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_FLAGS = 5'h04;
  localparam logic [4:0] OFS_DATA = 5'h08;
  localparam logic [4:0] OFS_THR_LO = 5'h0C;
  localparam logic [4:0] OFS_THR_HI = 5'h10;
  localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
  localparam logic [4:0] OFS_IRQ_CLR = 5'h18;
  localparam logic [4:0] OFS_IRQ_EN = 5'h1C;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int CTRL_W = 9;
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam int FLG_BROWNOUT = 0;
  localparam int FLG_INT = 1;
  localparam int FLG_BUSY = 2;
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_THR = 1;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 2'h0;
  localparam logic [15:0] THR_LO_RST = 16'h0000;
  localparam logic [15:0] THR_HI_RST = 16'hFFFF;
  localparam logic [15:0] DATA_RST = 16'h0000;

  // Consecutive out-of-window results needed before the flag rises
  localparam logic [4:0] PERSIST_N0 = 5'h01;
  localparam logic [4:0] PERSIST_N1 = 5'h04;
  localparam logic [4:0] PERSIST_N2 = 5'h08;
  localparam logic [4:0] PERSIST_N3 = 5'h10;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    MODE_PD = 2'b00,
    MODE_CONT = 2'b01,
    MODE_AUTO = 2'b10,
    MODE_RSVD = 2'b11
  } alsc_mode_e;

  typedef enum logic {
    ST_OFF = 1'b0,
    ST_CONV = 1'b1
  } alsc_state_e;

  // Bits 8..0 of the control register
  typedef struct packed {
    logic [1:0] persist;
    logic osc_fast;
    logic [1:0] res;
    logic [1:0] range;
    alsc_mode_e mode;
  } alsc_ctrl_s;

  typedef struct packed {
    logic busy;
    logic done;
    logic [ADC_BITS-1:0] raw;
  } alsc_conv_s;

endpackage

// *** src/alsc_conv.sv ***
// Charge-balancing conversion counter of the light sensor control
module alsc_conv #(
  parameter int TICK_CYC = 160
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [1:0] res_i,
  input wire logic osc_fast_i,
  input wire logic comp_i,
  output alsc_pkg::alsc_conv_s conv_o
);

  localparam int HALF_CYC =
    (TICK_CYC / 2 < alsc_pkg::TICK_MIN) ? alsc_pkg::TICK_MIN : TICK_CYC / 2;
  localparam logic [alsc_pkg::DIV_W-1:0] LIM_SLOW =
    alsc_pkg::DIV_W'(TICK_CYC - 1);
  localparam logic [alsc_pkg::DIV_W-1:0] LIM_FAST =
    alsc_pkg::DIV_W'(HALF_CYC - 1);

  logic busy_ff;
  logic done_ff;
  logic [alsc_pkg::DIV_W-1:0] div_ff;
  logic tick_ff;
  logic [16:0] n_ff;
  logic [16:0] ones_ff;
  logic [15:0] raw_ff;
  logic [16:0] last_n;
  logic [16:0] ones_now;

  ////////////////////////////////////////////////////////////////////////////
  // Sample enable; the fast oscillator halves the time per count (R01)
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end else if (!busy_ff || start_i) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end else if (div_ff >= (osc_fast_i ? LIM_FAST : LIM_SLOW)) begin // R01
      div_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      div_ff <= div_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  // Lower resolution shortens the conversion: 2^(16-4*res) samples (R01)
  assign last_n = (17'h00001 << (5'h10 - {1'b0, res_i, 2'b00})) - 17'h00001;
  assign ones_now = ones_ff + {16'h0000, comp_i};

  ////////////////////////////////////////////////////////////////////////////
  // Count charge packets over the integration window
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      n_ff <= '0;
      ones_ff <= '0;
      raw_ff <= 16'h0000;
    end else begin
      done_ff <= 1'b0;
      if (abort_i) begin
        busy_ff <= 1'b0;
      end else if (start_i) begin
        busy_ff <= 1'b1;
        n_ff <= '0;
        ones_ff <= '0;
      end else if (busy_ff && tick_ff) begin
        if (n_ff == last_n) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
          // Full window of 65536 ones saturates at full scale
          raw_ff <= ones_now[16] ? 16'hFFFF : ones_now[15:0]; // R01
        end else begin
          n_ff <= n_ff + 17'h00001;
          ones_ff <= ones_now;
        end
      end
    end
  end

  assign conv_o.busy = busy_ff;
  assign conv_o.done = done_ff;
  assign conv_o.raw = raw_ff;

endmodule

// *** bench/alsc_top_assertions.sv ***
// Concurrent checks on the ports of the light sensor control
module alsc_top_checker (
  input logic clock_i,
  input logic rst_b_i,
  input logic [4:0] avs_address_i,
  input logic avs_read_i,
  input logic avs_write_i,
  input logic [31:0] avs_writedata_i,
  input logic [3:0] avs_byteenable_i,
  input logic [31:0] avs_readdata_o,
  input logic avs_waitrequest_o,
  input logic comp_i,
  input logic int_o,
  input logic int_oe_o,
  input logic irq_o,
  input logic powered_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic done_wr, ctrl_wr, clr_int, en_off;
  assign done_wr = avs_write_i && !avs_waitrequest_o;
  assign ctrl_wr = done_wr && avs_address_i == alsc_pkg::OFS_CTRL;
  assign clr_int = done_wr && avs_address_i == alsc_pkg::OFS_FLAGS &&
                   avs_writedata_i[alsc_pkg::FLG_INT] && avs_byteenable_i[0];
  assign en_off = done_wr && avs_address_i == alsc_pkg::OFS_IRQ_EN &&
                  avs_writedata_i[1:0] == 2'h0 && avs_byteenable_i[0];
  // Continuous mode restarts by itself, so a wake there is legal
  logic cont_mode;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cont_mode <= 1'b0;
    end else if (ctrl_wr && avs_byteenable_i[0]) begin
      cont_mode <= avs_writedata_i[1:0] == 2'h1;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  ////////////////////////////////////////////////////////////////////////////
  property p_pin_low;
    int_o == 1'b0;
  endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("interrupt pin value not low");
  property p_oe_hold;
    int_oe_o && !clr_int && !$past(clr_int) |=> int_oe_o;
  endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("interrupt released without a clear");
  property p_wait_one;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("access not answered after one wait state");
  property p_wait_back;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_back: assert property (p_wait_back)
    else $error("waitrequest low longer than one cycle");
  property p_irq_off;
    en_off |-> ##2 !irq_o;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt output high with all enables off");
  property p_pd_stay;
    !powered_o && !cont_mode && !ctrl_wr && !$past(ctrl_wr) &&
      !$past(ctrl_wr, 2) |=> !powered_o;
  endproperty
  a_pd_stay: assert property (p_pd_stay)
    else $error("converter woke without a control write");
  property p_cont_run;
    cont_mode && !powered_o && !ctrl_wr |-> ##[1:3] powered_o;
  endproperty
  a_cont_run: assert property (p_cont_run)
    else $error("continuous conversions stalled");
  property p_pd_abort;
    ctrl_wr && avs_writedata_i[1:0] == 2'h0 |-> ##[1:4] !powered_o;
  endproperty
  a_pd_abort: assert property (p_pd_abort)
    else $error("power-down write did not stop the converter");
  property p_data_w;
    avs_read_i && !avs_waitrequest_o && avs_address_i == alsc_pkg::OFS_DATA
      |-> avs_readdata_o[31:16] == 16'h0000;
  endproperty
  a_data_w: assert property (p_data_w)
    else $error("result wider than sixteen bits");
endmodule

// *** bench/alsc_light.sv ***
// Light source model that feeds the modulator comparator bit
module alsc_light (
  input wire logic clock_i,
  input wire logic bright_i,
  output logic comp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bright light saturates the modulator, darkness never trips it
  always_ff @(posedge clock_i) begin
    comp_o <= bright_i;
  end
endmodule

// *** bench/tb_ambient_light_sensor_control.sv ***
// Self-checking bench of the light sensor control
module tb_ambient_light_sensor_control;
  timeunit 1ns;
  timeprecision 1ps;
  // Two cycles per sample keep a 4-bit conversion at 32 cycles
  localparam int CC = 65536 * 2;
  logic clock_i, rst_b_i, rd, wr, bright, comp;
  logic wait_o, int_o, int_oe_o, irq_o, powered_o;
  logic [4:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata, q;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  alsc_top #(.CONV_CYC(CC)) dut_u (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_o), .comp_i(comp), .int_o(int_o),
    .int_oe_o(int_oe_o), .irq_o(irq_o), .powered_o(powered_o));
  alsc_light light_u (.clock_i(clock_i), .bright_i(bright), .comp_o(comp));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Entered just after a rising edge; one idle cycle follows each access
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    // Only the global cycle ceiling ends a hung wait
    do begin
      @(posedge clock_i);
    end while (wait_o !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clock_i);
  endtask
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic pause(input int c);
    repeat (c) @(posedge clock_i);
  endtask
  task automatic idle();
    int n;
    n = 0;
    pause(4);
    while (powered_o === 1'b1 && n < 3000) begin
      @(posedge clock_i);
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rchk(alsc_pkg::OFS_FLAGS, 32'h1);
    rchk(alsc_pkg::OFS_CTRL, 32'h0);
    rchk(alsc_pkg::OFS_THR_LO, 32'h0);
    rchk(alsc_pkg::OFS_THR_HI, 32'hFFFF);
    rchk(alsc_pkg::OFS_IRQ_EN, 32'h0);
    rchk(alsc_pkg::OFS_IRQ_CLR, 32'h0);
    be <= 4'h0;
    bus(1'b1, alsc_pkg::OFS_FLAGS, 32'h1);
    be <= 4'hF;
    rchk(alsc_pkg::OFS_FLAGS, 32'h1);
    bus(1'b1, alsc_pkg::OFS_FLAGS, 32'h1);
    rchk(alsc_pkg::OFS_FLAGS, 32'h0);
    chk(int_oe_o, 1'b0);
  endtask
  task automatic t_auto();
    bright <= 1'b1;
    pause(4);
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, alsc_pkg::OFS_CTRL, 32'h32 | (r << 2));
      idle();
      chk(powered_o, 1'b0);
      rchk(alsc_pkg::OFS_DATA, 32'd16 >> (2 * r));
    end
    rchk(alsc_pkg::OFS_IRQ_STAT, 32'h1);
    bus(1'b1, alsc_pkg::OFS_IRQ_CLR, 32'h1);
    rchk(alsc_pkg::OFS_IRQ_STAT, 32'h0);
    bus(1'b1, alsc_pkg::OFS_CTRL, 32'h22);
    idle();
    rchk(alsc_pkg::OFS_DATA, 32'd256);
  endtask
  task automatic t_pd();
    bus(1'b1, alsc_pkg::OFS_CTRL, 32'h31);
    pause(10);
    chk(powered_o, 1'b1);
    bus(1'b1, alsc_pkg::OFS_CTRL, 32'h0);
    pause(4);
    chk(powered_o, 1'b0);
    pause(100);
    chk(powered_o, 1'b0);
  endtask
  task automatic t_int();
    bus(1'b1, alsc_pkg::OFS_THR_HI, 32'h5);
    bus(1'b1, alsc_pkg::OFS_IRQ_CLR, 32'h3);
    bus(1'b1, alsc_pkg::OFS_IRQ_EN, 32'h3);
    bus(1'b1, alsc_pkg::OFS_CTRL, 32'h31);
    pause(80);
    chk(int_oe_o, 1'b1);
    chk(irq_o, 1'b1);
    bus(1'b0, alsc_pkg::OFS_FLAGS, 32'h0);
    chk(q[1:0], 2'h2);
    bus(1'b1, alsc_pkg::OFS_IRQ_CLR, 32'h1);
    pause(80);
    rchk(alsc_pkg::OFS_IRQ_STAT, 32'h3);
    bus(1'b1, alsc_pkg::OFS_CTRL, 32'h0);
    pause(50);
    chk(int_oe_o, 1'b1);
    chk(irq_o, 1'b1);
    bus(1'b1, alsc_pkg::OFS_FLAGS, 32'h2);
    pause(3);
    chk(int_oe_o, 1'b0);
    bus(1'b1, alsc_pkg::OFS_IRQ_EN, 32'h0);
    pause(3);
    chk(irq_o, 1'b0);
    bus(1'b1, alsc_pkg::OFS_IRQ_CLR, 32'h3);
    bus(1'b1, alsc_pkg::OFS_IRQ_EN, 32'h3);
    pause(3);
    chk(irq_o, 1'b0);
  endtask
  // Dark result sits inside the window and clears the persistence count
  task automatic t_persist();
    bright <= 1'b0;
    pause(4);
    bus(1'b1, alsc_pkg::OFS_CTRL, 32'h32);
    idle();
    rchk(alsc_pkg::OFS_DATA, 32'h0);
    bright <= 1'b1;
    pause(4);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, alsc_pkg::OFS_CTRL, 32'hB2);
      idle();
      bus(1'b0, alsc_pkg::OFS_FLAGS, 32'h0);
      chk(q[alsc_pkg::FLG_INT], i == 3);
    end
    pause(2);
    chk(int_oe_o, 1'b1);
  endtask
  // Slow run is 16 samples of two cycles, fast run about half of that
  task automatic t_fast();
    int n;
    for (int f = 0; f < 2; f++) begin
      n = 0;
      bus(1'b1, alsc_pkg::OFS_CTRL, 32'h32 | (f << 6));
      pause(1);
      while (powered_o === 1'b1 && n < 100) begin
        @(posedge clock_i);
        n++;
      end
      chk(n < 24, f == 1);
      rchk(alsc_pkg::OFS_DATA, 32'd16);
    end
  endtask
  // Power cycle after the last auto run has ended: brownout returns, the pin lets go
  task automatic t_rst2();
    rst_b_i <= 1'b0;
    pause(3);
    chk(int_oe_o, 1'b0);
    rst_b_i <= 1'b1;
    pause(1);
    rchk(alsc_pkg::OFS_FLAGS, 32'h1);
    rchk(alsc_pkg::OFS_IRQ_STAT, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      wrap_up();
    end
  end
  initial begin
    rst_b_i = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = 5'h00;
    wdata = 32'h0;
    be = 4'hF;
    bright = 1'b0;
    repeat (16) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    t_reset();
    t_auto();
    t_fast();
    t_pd();
    t_int();
    t_persist();
    t_rst2();
    wrap_up();
  end
endmodule

bind alsc_top alsc_top_checker chk_u (.clock_i(clock_i), .rst_b_i(rst_b_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .comp_i(comp_i), .int_o(int_o),
  .int_oe_o(int_oe_o), .irq_o(irq_o), .powered_o(powered_o));
